/* inc/ssr_regs.vh */
/*
 Wake-reception constants for the serial wake_reception_mode receive block.
 Assumes inclusion by the design file by bare name; definitions only.
*/
`ifndef SSR_REGS_VH
`define SSR_REGS_VH
// ---------------------------------------------------------------
// Register offsets (plain register port, 4-bit address)
// ---------------------------------------------------------------
`define SSR_OFS_CTRL 4'h0
`define SSR_OFS_CH0_DATA 4'h1
`define SSR_OFS_CH1_DATA 4'h2
`define SSR_OFS_STATUS 4'h3
`define SSR_OFS_TRIG 4'h4
// ---------------------------------------------------------------
// Control register fields
// ---------------------------------------------------------------
`define SSR_CTRL_WAKE 0
`define SSR_CTRL_EIE 1
`define SSR_CTRL_SUPP 2
`define SSR_CTRL_PRESC_LSB 4
`define SSR_CTRL_PRESC_W 4
// Trigger register fields (write one to act).
`define SSR_TRIG_START0 0
`define SSR_TRIG_STOP0 1
`define SSR_TRIG_START1 2
`define SSR_TRIG_STOP1 3
`define SSR_TRIG_CLRERR 4
// Status register fields.
`define SSR_ST_EN0 0
`define SSR_ST_EN1 1
`define SSR_ST_BFF1 2
`define SSR_ST_OVF1 3
`define SSR_ST_PEF 4
`define SSR_ST_FEF 5
`define SSR_ST_WAKE 6
`define SSR_ST_BFF0 7
// Divider field of channel data registers.
`define SSR_DIV_LSB 9
`define SSR_DIV_MSB 15
// Reset value of registers.
`define SSR_RST_VAL 16'h0000
`endif

/* rtl/ssr_top.v */
/*
 Serial wake_reception_mode receive: wake reception of one clocked-serial frame on
 channel 0 or one asynchronous frame on channel 1 while the CPU is stopped.
 Assumes the high-speed oscillator clock clock_i keeps running in STOP and
 that software arms the mode as described in the behaviour list.
*/
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`include "ssr_regs.vh"
module ssr_top #(
   parameter INSTANCE = 0,
   parameter PARITY_EN = 1
) (
   // Clock and reset.
   input wire clock_i,
   input wire nrst_i,
   // Register port.
   input wire [3:0] addr_i,
   input wire [15:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output reg [15:0] rdata_o,
   // System state.
   input wire cpu_stop_i,
   // Serial pins.
   input wire serial_clock_pin_i,
   input wire serial_data_pin_i,
   input wire async_receive_pin_i,
   // Events to the system.
   output reg clocked_serial_done_irq_o,
   output reg async_receive_done_irq_o,
   output reg async0_error_irq_o,
   output reg wake_reception_mode_o,
   output reg wake_exit_o
);
   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   reg [15:0] ctrl_r, chan0_data_divider_reg_r, chan1_data_divider_reg_r, tick_cnt_r;
   reg chan0_enable_status_r, chan1_enable_status_r, chan0_full_r;
   reg chan1_buffer_full_flag_r, chan1_overrun_flag_r, parity_error_flag_r, framing_error_flag_r;
   reg [2:0] sck_s_r, rxd_s_r;
   reg [1:0] sdi_s_r;
   reg [3:0] sbit_cnt_r, abit_cnt_r;
   reg [7:0] sshift_r;
   reg [8:0] ashift_r;
   reg [4:0] st_r;
   wire standby_wake_ctrl = ctrl_r[`SSR_CTRL_WAKE];
   wire error_irq_enable = ctrl_r[`SSR_CTRL_EIE];
   wire wake_error_suppress = ctrl_r[`SSR_CTRL_SUPP];
   wire [3:0] presc = ctrl_r[`SSR_CTRL_PRESC_LSB +: `SSR_CTRL_PRESC_W];
   wire [6:0] div1 = chan1_data_divider_reg_r[`SSR_DIV_MSB:`SSR_DIV_LSB];
   // wake gate: bit set and CPU stopped.
   wire wake_on = standby_wake_ctrl && cpu_stop_i;
   // only instance 0 may run async in wake.
   wire async_ok = (INSTANCE == 0);
   // Bit period (div+1) << prescaler; reloads use one less, since the zero count takes a cycle too.
   wire [15:0] bit_len = ({9'h000, div1} + 16'h0001) << presc;
   wire [15:0] half_len = {1'b0, bit_len[15:1]};
   // ---------------------------------------------------------------
   // Pin synchronisers and edge detection
   // ---------------------------------------------------------------
   // two flops before use; third stage only for edges.
   always @(posedge clock_i) begin
      if (!nrst_i) begin
         sck_s_r <= 3'h0;
         rxd_s_r <= 3'h7;
         sdi_s_r <= 2'h0;
      end else begin
         sck_s_r <= {sck_s_r[1:0], serial_clock_pin_i};
         rxd_s_r <= {rxd_s_r[1:0], async_receive_pin_i};
         sdi_s_r <= {sdi_s_r[0], serial_data_pin_i};
      end
   end
   wire sck_rise = sck_s_r[1] && !sck_s_r[2];
   wire rxd_fall = !rxd_s_r[1] && rxd_s_r[2];
   wire rxd = rxd_s_r[1];
   // ---------------------------------------------------------------
   // Async receive state machine
   // ---------------------------------------------------------------
   localparam ST_IDLE = 5'h01;
   localparam ST_START = 5'h02;
   localparam ST_DATA = 5'h04;
   localparam ST_STOP = 5'h08;
   localparam ST_DONE = 5'h10;
   // Frame length in data bits plus optional parity.
   localparam [3:0] NBITS = (PARITY_EN != 0) ? 4'h9 : 4'h8;
   wire tick_end = (tick_cnt_r == 16'h0000);
   wire par_bad = (PARITY_EN != 0) && (^ashift_r);
   wire wr_trig = wr_i && (addr_i == `SSR_OFS_TRIG);
   wire clr_err = wr_trig && wdata_i[`SSR_TRIG_CLRERR];
   wire a_done = (st_r == ST_STOP) && tick_end;
   wire frame_err = a_done && !rxd;
   wire parity_err = a_done && par_bad;
   wire overrun = a_done && chan1_buffer_full_flag_r;
   wire any_err = frame_err || parity_err || overrun;
   // the trade-off: a frame begun outside STOP is still taken.
   always @(posedge clock_i) begin
      if (!nrst_i) begin
         st_r <= ST_IDLE;
         tick_cnt_r <= 16'h0000;
         abit_cnt_r <= 4'h0;
         ashift_r <= 9'h000;
      end else begin
         case (st_r)
            ST_IDLE: begin
               // start-bit edge; runs with CPU stopped.
               if (chan1_enable_status_r && rxd_fall && (async_ok || !standby_wake_ctrl)) begin
                  st_r <= ST_START;
                  tick_cnt_r <= half_len;
               end
            end
            ST_START: begin
               if (tick_end) begin
                  st_r <= rxd ? ST_IDLE : ST_DATA;
                  tick_cnt_r <= bit_len - 16'h0001;
                  abit_cnt_r <= 4'h0;
               end else begin
                  tick_cnt_r <= tick_cnt_r - 16'h0001;
               end
            end
            ST_DATA: begin
               if (tick_end) begin
                  ashift_r <= {rxd, ashift_r[8:1]};
                  abit_cnt_r <= abit_cnt_r + 4'h1;
                  tick_cnt_r <= bit_len - 16'h0001;
                  if (abit_cnt_r == NBITS - 4'h1) begin
                     st_r <= ST_STOP;
                  end
               end else begin
                  tick_cnt_r <= tick_cnt_r - 16'h0001;
               end
            end
            ST_STOP: begin
               if (tick_end) begin
                  st_r <= ST_DONE;
               end else begin
                  tick_cnt_r <= tick_cnt_r - 16'h0001;
               end
            end
            default: begin
               st_r <= ST_IDLE;
            end
         endcase
      end
   end
   // ---------------------------------------------------------------
   // Clocked-serial slave receive (channel 0)
   // ---------------------------------------------------------------
   wire s_done = chan0_enable_status_r && sck_rise && (sbit_cnt_r == 4'h7);
   // while channel 0 is enabled, each synchronised serial clock rising edge shifts one bit.
   always @(posedge clock_i) begin
      if (!nrst_i) begin
         sbit_cnt_r <= 4'h0;
         sshift_r <= 8'h00;
      end else if (!chan0_enable_status_r) begin
         sbit_cnt_r <= 4'h0;
      end else if (sck_rise) begin
         sshift_r <= {sshift_r[6:0], sdi_s_r[1]};
         sbit_cnt_r <= (sbit_cnt_r == 4'h7) ? 4'h0 : sbit_cnt_r + 4'h1;
      end
   end
   // ---------------------------------------------------------------
   // Software registers, flags and channel enables
   // ---------------------------------------------------------------
   // Hardware sets beat software clears for every flag.
   always @(posedge clock_i) begin
      if (!nrst_i) begin
         ctrl_r <= `SSR_RST_VAL;
         chan0_data_divider_reg_r <= `SSR_RST_VAL;
         chan1_data_divider_reg_r <= `SSR_RST_VAL;
         chan0_enable_status_r <= 1'b0;
         chan1_enable_status_r <= 1'b0;
         chan0_full_r <= 1'b0;
         chan1_buffer_full_flag_r <= 1'b0;
         chan1_overrun_flag_r <= 1'b0;
         parity_error_flag_r <= 1'b0;
         framing_error_flag_r <= 1'b0;
      end else begin
         if (wr_i && (addr_i == `SSR_OFS_CTRL)) begin
            ctrl_r <= wdata_i;
         end
         // Divider bits only accept writes while the channel is stopped.
         if (wr_i && (addr_i == `SSR_OFS_CH0_DATA) && !chan0_enable_status_r) begin
            chan0_data_divider_reg_r[`SSR_DIV_MSB:`SSR_DIV_LSB] <= wdata_i[`SSR_DIV_MSB:`SSR_DIV_LSB];
         end
         if (wr_i && (addr_i == `SSR_OFS_CH1_DATA) && !chan1_enable_status_r) begin
            chan1_data_divider_reg_r[`SSR_DIV_MSB:`SSR_DIV_LSB] <= wdata_i[`SSR_DIV_MSB:`SSR_DIV_LSB];
         end
         if (wr_trig && wdata_i[`SSR_TRIG_START0]) begin
            chan0_enable_status_r <= 1'b1;
         end else if (wr_trig && wdata_i[`SSR_TRIG_STOP0]) begin
            chan0_enable_status_r <= 1'b0;
         end
         if (wr_trig && wdata_i[`SSR_TRIG_START1]) begin
            chan1_enable_status_r <= 1'b1;
         end else if (wr_trig && wdata_i[`SSR_TRIG_STOP1]) begin
            chan1_enable_status_r <= 1'b0;
         end
         if (s_done) begin
            chan0_data_divider_reg_r[7:0] <= {sshift_r[6:0], sdi_s_r[1]};
            chan0_full_r <= 1'b1;
         end else if (rd_i && (addr_i == `SSR_OFS_CH0_DATA)) begin
            chan0_full_r <= 1'b0;
         end
         if (a_done) begin
            chan1_data_divider_reg_r[8:0] <= ashift_r;
         end
         // full and overrun flags frozen in wake.
         if (!standby_wake_ctrl) begin
            if (a_done) begin
               chan1_buffer_full_flag_r <= 1'b1;
            end else if (rd_i && (addr_i == `SSR_OFS_CH1_DATA)) begin
               chan1_buffer_full_flag_r <= 1'b0;
            end
            if (overrun) begin
               chan1_overrun_flag_r <= 1'b1;
            end else if (clr_err) begin
               chan1_overrun_flag_r <= 1'b0;
            end
         end
         // suppress blocks parity and framing flags while the wake bit is set.
         if ((frame_err || parity_err) && !(standby_wake_ctrl && wake_error_suppress)) begin
            parity_error_flag_r <= parity_error_flag_r | parity_err;
            framing_error_flag_r <= framing_error_flag_r | frame_err;
         end else if (clr_err) begin
            parity_error_flag_r <= 1'b0;
            framing_error_flag_r <= 1'b0;
         end
      end
   end
   // ---------------------------------------------------------------
   // Interrupts, wake state and read data
   // ---------------------------------------------------------------
   // error interrupt from enable and suppress together.
   // enable clear gives none; enable set, suppress clear gives one.
   wire err_irq = any_err && error_irq_enable && !(standby_wake_ctrl && wake_error_suppress);
   always @(posedge clock_i) begin
      if (!nrst_i) begin
         clocked_serial_done_irq_o <= 1'b0;
         async_receive_done_irq_o <= 1'b0;
         async0_error_irq_o <= 1'b0;
         wake_reception_mode_o <= 1'b0;
         wake_exit_o <= 1'b0;
         rdata_o <= 16'h0000;
      end else begin
         clocked_serial_done_irq_o <= s_done;
         // transfer-end pulse withheld when the error interrupt fires.
         async_receive_done_irq_o <= a_done && !err_irq;
         async0_error_irq_o <= err_irq;
         // wake mode entered on a pin edge, left on completion.
         if (!wake_on || wake_exit_o) begin
            wake_reception_mode_o <= 1'b0;
         end else if ((chan0_enable_status_r && sck_rise) || (chan1_enable_status_r && rxd_fall && async_ok)) begin
            wake_reception_mode_o <= 1'b1;
         end
         wake_exit_o <= wake_reception_mode_o && (s_done || a_done);
         rdata_o <= 16'h0000;
         if (rd_i) begin
            case (addr_i)
               `SSR_OFS_CTRL: rdata_o <= ctrl_r;
               // Divider bits read as zero while the channel runs.
               `SSR_OFS_CH0_DATA: rdata_o <= chan0_enable_status_r ?
                  {8'h00, chan0_data_divider_reg_r[7:0]} : chan0_data_divider_reg_r;
               `SSR_OFS_CH1_DATA: rdata_o <= chan1_enable_status_r ?
                  {7'h00, chan1_data_divider_reg_r[8:0]} : chan1_data_divider_reg_r;
               `SSR_OFS_STATUS: rdata_o <= {8'h00, chan0_full_r, wake_reception_mode_o, framing_error_flag_r,
                  parity_error_flag_r, chan1_overrun_flag_r, chan1_buffer_full_flag_r,
                  chan1_enable_status_r, chan0_enable_status_r};
               default: rdata_o <= 16'h0000;
            endcase
         end
      end
   end
endmodule // ssr_top

/* tb/ssr_far_tx.sv */
/*
 Far-side sender: clocked-serial master and asynchronous transmitter.
 Assumes the bench starts one frame at a time.
*/
module ssr_far_tx #(
   parameter real BIT_NS = 160.0
) (
   // Pins towards the block.
   output logic sck_o,
   output logic sdo_o,
   output logic rxd_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // both rates are scaled with the oscillator clock; each bit still spans many of its cycles.
   // Clock stands low between frames; the asynchronous line idles at mark.
   initial begin
      sck_o = 1'b0;
      sdo_o = 1'b0;
      rxd_o = 1'b1;
   end
   // Eight bits MSB first, data changed while the clock is low.
   task automatic send_sync(input logic [7:0] b);
      // Every pin change lands off the bench clock's rising edge.
      #2;
      for (int i = 7; i >= 0; i--) begin
         sdo_o = b[i];
         #62.5 sck_o = 1'b1;
         #62.5 sck_o = 1'b0;
      end
      // Released line shows the inverse, so a stale sample cannot pass.
      sdo_o = ~sdo_o;
   endtask
   // Start, eight bits LSB first, even parity (broken on request), one stop.
   task automatic send_async(input logic [7:0] b, input logic bad);
      #2;
      rxd_o = 1'b0;
      #(BIT_NS);
      for (int i = 0; i < 9; i++) begin
         rxd_o = (i < 8) ? b[i[2:0]] : (^b ^ bad);
         #(BIT_NS);
      end
      rxd_o = 1'b1;
      #(BIT_NS);
   endtask
endmodule // ssr_far_tx

/* tb/ssr_props.sv */
/*
 Port checker for the serial wake_reception_mode receive block.
 Assumes it is bound to ssr_top and sees nothing but its ports.
*/
`include "ssr_regs.vh"
module ssr_props (
   // Clock, reset and register port.
   input wire clock_i,
   input wire nrst_i,
   input wire [3:0] addr_i,
   input wire [15:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   input wire [15:0] rdata_o,
   // System state and events.
   input wire cpu_stop_i,
   input wire clocked_serial_done_irq_o,
   input wire async_receive_done_irq_o,
   input wire async0_error_irq_o,
   input wire wake_reception_mode_o,
   input wire wake_exit_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // Shadow of the control bits, since the error gate is not visible at the pins.
   reg [2:0] ctrl_r;
   always @(posedge clock_i) begin
      if (!nrst_i) begin
         ctrl_r <= 3'h0;
      end else if (wr_i && addr_i == `SSR_OFS_CTRL) begin
         ctrl_r <= wdata_i[2:0];
      end
   end
   default clocking @(posedge clock_i); endclocking
   default disable iff (!nrst_i);
   a_rdata_slot: assert property (rdata_o != 16'h0 |-> $past(rd_i))
      else $error("read data outside its slot");
   a_wake_needs_stop: assert property (!(ctrl_r[0] && cpu_stop_i) |=> !wake_reception_mode_o)
      else $error("wake mode without wake bit and stop");
   a_wake_entry_cause: assert property ($rose(wake_reception_mode_o) |-> $past(cpu_stop_i && ctrl_r[0]))
      else $error("wake mode entered outside stop");
   a_exit_after_done: assert property (clocked_serial_done_irq_o && wake_reception_mode_o |-> wake_exit_o)
      else $error("no return after serial completion");
   a_exit_leaves_wake: assert property (wake_exit_o |-> ##[0:1] !wake_reception_mode_o)
      else $error("wake mode kept after return");
   a_err_needs_enable: assert property (async0_error_irq_o |-> $past(ctrl_r[1]))
      else $error("error interrupt while disabled");
   a_err_not_suppressed: assert property (async0_error_irq_o |-> !$past(ctrl_r[2] && ctrl_r[0]))
      else $error("error interrupt while suppressed");
   a_rx_done_pulse: assert property ($rose(async_receive_done_irq_o) |=> !async_receive_done_irq_o)
      else $error("frame end interrupt longer than a cycle");
   c_serial_done: cover property (clocked_serial_done_irq_o);
   c_error_irq: cover property (async0_error_irq_o);
   c_wake_exit: cover property (wake_exit_o);
endmodule // ssr_props
bind ssr_top ssr_props i_props (.clock_i(clock_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
   .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .cpu_stop_i(cpu_stop_i),
   .clocked_serial_done_irq_o(clocked_serial_done_irq_o), .async_receive_done_irq_o(async_receive_done_irq_o),
   .async0_error_irq_o(async0_error_irq_o), .wake_reception_mode_o(wake_reception_mode_o),
   .wake_exit_o(wake_exit_o));

/* tb/tb_top.sv */
/*
 Self-checking bench: register rows, then clocked-serial and asynchronous wake frames.
 Assumes the sender model ssr_far_tx and the bound port checker.
*/
`include "ssr_regs.vh"
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic clock_i = 1'b0;
   logic nrst_i = 1'b0;
   logic [3:0] addr_i = 4'h0;
   logic [15:0] wdata_i = 16'h0;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic cpu_stop_i = 1'b0;
   wire sck, sdo, rxd, cs_done, rx_done, err_irq, wake, wexit, rx_done1, err_irq1;
   wire [15:0] rdata_o;
   int n_fail = 0;
   int compares = 0;
   logic [15:0] v;
   logic got_done, got_err, eie, supp, bad;
   logic got1 = 1'b0;
   // Ordinary cases: address, written value, value read back (unmapped reads 0).
   // Data registers take only their divider bits from software while the channel is stopped.
   logic [3:0] row_a [4] = '{4'h0, 4'h1, 4'h2, 4'h7};
   logic [15:0] row_w [4] = '{16'h0036, 16'h1234, 16'hab55, 16'hffff};
   logic [15:0] row_e [4] = '{16'h0036, 16'h1200, 16'haa00, 16'h0000};
   initial forever #5 clock_i = ~clock_i;
   ssr_top i_dut (.clock_i(clock_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .cpu_stop_i(cpu_stop_i), .serial_clock_pin_i(sck),
      .serial_data_pin_i(sdo), .async_receive_pin_i(rxd), .clocked_serial_done_irq_o(cs_done),
      .async_receive_done_irq_o(rx_done), .async0_error_irq_o(err_irq), .wake_reception_mode_o(wake),
      .wake_exit_o(wexit));
   // a second instance that must stay deaf to asynchronous wake frames.
   ssr_top #(.INSTANCE(1)) i_dut1 (.clock_i(clock_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(), .cpu_stop_i(cpu_stop_i), .serial_clock_pin_i(sck),
      .serial_data_pin_i(sdo), .async_receive_pin_i(rxd), .clocked_serial_done_irq_o(),
      .async_receive_done_irq_o(rx_done1), .async0_error_irq_o(err_irq1), .wake_reception_mode_o(),
      .wake_exit_o());
   ssr_far_tx #(.BIT_NS(160.0)) i_far (.sck_o(sck), .sdo_o(sdo), .rxd_o(rxd));
   task automatic report_and_stop();
      $display("compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   // Strobes last one cycle; the following edge passes before the next request.
   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clock_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clock_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
      @(posedge clock_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clock_i);
      rd_i <= 1'b0;
      #1;
      d = rdata_o;
   endtask
   task automatic sample();
      @(posedge clock_i);
      #1;
      got_done = got_done | rx_done;
      got_err = got_err | err_irq;
      got1 = got1 | rx_done1 | err_irq1;
   endtask
   // Waits for the first event pulse; a spent bound ends the run.
   task automatic wait_irq(input int bound);
      int i;
      got_done = 1'b0;
      got_err = 1'b0;
      for (i = 0; i < bound; i++) begin
         sample();
         if (got_done || got_err || cs_done) break;
      end
      if (i == bound) begin
         n_fail++;
         $display("MISMATCH at %0t: no event from the receiver", $time);
         report_and_stop();
      end
   endtask
   initial begin
      repeat (12) @(posedge clock_i);
      nrst_i <= 1'b1;
      for (int a = 0; a < 4; a++) begin
         rd_reg(a[3:0], v);
         chk(v, `SSR_RST_VAL, "reset value");
      end
      $display("test reset done");
      for (int r = 0; r < 4; r++) begin
         wr_reg(row_a[r], row_w[r]);
         rd_reg(row_a[r], v);
         chk(v, row_e[r], "register row");
      end
      $display("test register rows done");
      wr_reg(`SSR_OFS_CH0_DATA, 16'h0000);
      wr_reg(`SSR_OFS_CTRL, 16'h0001);
      wr_reg(`SSR_OFS_TRIG, 16'h0001);
      cpu_stop_i <= 1'b1;
      fork
         i_far.send_sync(8'ha5);
      join_none
      wait_irq(400);
      chk(cs_done, 1'b1, "serial done");
      chk(wake, 1'b1, "wake mode in frame");
      chk(wexit, 1'b1, "return to normal");
      @(posedge clock_i);
      #1;
      chk(wake, 1'b0, "wake mode left");
      wait fork;
      @(posedge clock_i);
      cpu_stop_i <= 1'b0;
      rd_reg(`SSR_OFS_CH0_DATA, v);
      chk(v[7:0], 8'ha5, "serial byte");
      wr_reg(`SSR_OFS_TRIG, 16'h0002);
      wr_reg(`SSR_OFS_CTRL, 16'h0000);
      rd_reg(`SSR_OFS_STATUS, v);
      chk(v[`SSR_ST_EN0], 1'b0, "channel 0 stopped");
      $display("test clocked serial done");
      // wake baud: divider 15, sixteen clocks a bit
      wr_reg(`SSR_OFS_CH1_DATA, 16'h1e00);
      for (int k = 0; k < 5; k++) begin
         eie = (k == 4) || k[0];
         supp = (k < 4) && k[1];
         bad = (k < 4);
         // clear flags, read data before arming
         wr_reg(`SSR_OFS_TRIG, 16'h0010);
         rd_reg(`SSR_OFS_CH1_DATA, v);
         wr_reg(`SSR_OFS_CTRL, {13'h0, supp, eie, 1'b1});
         wr_reg(`SSR_OFS_TRIG, 16'h0004);
         cpu_stop_i <= 1'b1;
         fork
            i_far.send_async(8'h3c + k[7:0], bad);
         join_none
         wait_irq(600);
         repeat (3) sample();
         wait fork;
         chk(got_err, eie && !supp && bad, "error interrupt");
         chk(got_done, !(eie && !supp && bad), "frame end interrupt");
         @(posedge clock_i);
         cpu_stop_i <= 1'b0;
         rd_reg(`SSR_OFS_STATUS, v);
         chk(v[4], bad && !supp, "parity flag");
         chk(v[3:2], 2'b00, "full and overrun frozen");
         if (k == 4) begin
            rd_reg(`SSR_OFS_CH1_DATA, v);
            chk(v[7:0], 8'h40, "async byte");
         end
         wr_reg(`SSR_OFS_TRIG, 16'h0018);
         wr_reg(`SSR_OFS_CTRL, 16'h0000);
      end
      chk(got1, 1'b0, "other instance silent in wake");
      $display("test async frames done");
      report_and_stop();
   end
endmodule // tb_top
